// [itr_pkg.sv]
// Constants, field layout and shared decode for the indicator test/clear unit
package itr_pkg;
  // Operation codes are octal 64 (test) and octal 65 (clear)
  localparam logic [5:0] OP_TEST = 6'h34;
  localparam logic [5:0] OP_CLEAR = 6'h35;
  // Class field values
  localparam logic [3:0] CLS_CONT = 4'h2;
  localparam logic [3:0] CLS_PERR = 4'h1;
  // Instruction word field positions (bits numbered 25 down to 1)
  localparam int IND_BIT = 25;
  localparam int XR_HI = 24;
  localparam int XR_LO = 21;
  localparam int OP_HI = 20;
  localparam int OP_LO = 15;
  localparam int CLS_HI = 14;
  localparam int CLS_LO = 11;
  localparam int SEL_HI = 10;
  localparam int SEL_LO = 1;
  // Contingency indicators, one-hot in selection bits 1..6
  localparam int CONT_W = 6;
  localparam int CONT_OVF = 0;
  localparam int CONT_BADOP = 1;
  localparam int CONT_TYPE = 2;
  localparam int CONT_KBREQ = 3;
  localparam int CONT_KBREL = 4;
  localparam int CONT_STOP = 5;
  // Processor fault field: code 1..15 in bits 1..4, checks 16/32/64
  localparam int CODE_W = 4;
  localparam int CHK_W = 3;
  localparam int CHK_LO = 5;
  // Control counter width
  localparam int CC_W = 15;
  localparam logic [14:0] CC_STEP = 15'h0001;
  localparam logic [14:0] CC_SKIP = 15'h0002;
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  // Status and mask bit positions
  localparam int SB_W = 4;
  localparam int SB_TEST = 0;
  localparam int SB_CLEAR = 1;
  localparam int SB_CONT = 2;
  localparam int SB_PERR = 3;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // Flags register layout
  localparam int FL_CONT_LO = 0;
  localparam int FL_CODE_LO = 8;
  localparam int FL_CHK_LO = 12;
  localparam int FL_CMODE = 16;
  localparam int FL_PMODE = 17;
  localparam int FL_INH = 18;
  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_IND, ST_EXEC} itr_state_t;

  // True for the two operation codes this unit executes
  function automatic logic itr_is_op(input logic [5:0] op);
    itr_is_op = (op == OP_TEST) || (op == OP_CLEAR);
  endfunction
endpackage

// [itr_decode.sv]
// Instruction field decode and indicator selection for the test/clear unit
`timescale 1ns/10ps
`default_nettype none
module itr_decode (
  input wire logic [25:1] word,
  input wire logic [5:0] cont,
  input wire logic [3:0] code,
  input wire logic [2:0] chk,
  output logic isTest,
  output logic isClear,
  output logic [5:0] selCont,
  output logic codeSel,
  output logic [2:0] selChk,
  output logic anyCont,
  output logic anyPerr,
  output logic hit
);
  logic [5:0] op; // Operation code field
  logic [3:0] cls; // Class field
  logic [10:1] sel; // Indicator selection bits
  logic clsCont; // Contingency group addressed
  logic clsPerr; // Processor fault group addressed

  // Field extraction and selection masking
  always_comb begin
    op = word[itr_pkg::OP_HI:itr_pkg::OP_LO];
    cls = word[itr_pkg::CLS_HI:itr_pkg::CLS_LO];
    sel = word[itr_pkg::SEL_HI:itr_pkg::SEL_LO];
    isTest = itr_pkg::itr_is_op(op) && (op == itr_pkg::OP_TEST);
    isClear = itr_pkg::itr_is_op(op) && (op == itr_pkg::OP_CLEAR);
    clsCont = (cls == itr_pkg::CLS_CONT);
    clsPerr = (cls == itr_pkg::CLS_PERR);
    // Only bits 1..6 name contingency flags; 7..10 are ignored
    selCont = clsCont ? sel[6:1] : 6'h00;
    // Low four bits carry an address fault code, compared whole
    codeSel = clsPerr && (sel[4:1] != 4'h0);
    selChk = clsPerr ? sel[7:5] : 3'h0;
    anyCont = |selCont;
    anyPerr = codeSel || (|selChk);
    // Any selected flag set makes the test true
    hit = (|(selCont & cont)) || (|(selChk & chk))
      || (codeSel && (sel[4:1] == code));
  end
endmodule
`default_nettype wire

// [itr_unit.sv]
// Indicator test and clear execution unit with APB status window
// How it works
// - Test op 64: skip unless selected flag set
// - Testing never changes any indicator
// - Contingency select bits 1-6 and fault check bits 5-7 each pick one indicator
// - Class 0010 addresses contingency flags
// - Class 0001 addresses processor fault flags
// - Contingency flags one-hot, bits 7-10 zero
// - Fault codes 1-15 address, 16/32/64 checks
// - Clear op 65 drops selected flags, 2 cycles
// - Clearing an already clear flag is fine
// - Contingency clear ends mode, inhibits one instruction
// - Fault clear ends mode, inhibits one instruction
// - Word fields: indirect, index, op, class, select
// - Indirect word resolved before executing
`timescale 1ns/10ps
`default_nettype none
module itr_unit (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic instrValid,
  input wire logic [25:1] instrWord,
  input wire logic [14:0] ccIn,
  output logic instrReady,
  output logic indReq,
  output logic [14:1] indAddr,
  input wire logic [25:1] indData,
  input wire logic indAck,
  output logic execDone,
  output logic skipNext,
  output logic [14:0] ccNext,
  input wire logic [5:0] contEvent,
  input wire logic perrAddrEvent,
  input wire logic [3:0] perrAddrCode,
  input wire logic [2:0] perrChkEvent,
  input wire logic contIntTaken,
  input wire logic perrIntTaken,
  input wire logic instrRetire,
  output logic contMode,
  output logic perrMode,
  output logic intrInhibit,
  output logic contPending,
  output logic perrPending,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // Whole state of the unit
  typedef struct packed {
    itr_pkg::itr_state_t st; // Sequencer state
    logic [25:1] word; // Instruction held for execution
    logic [14:0] ccBase; // Counter value of this instruction
    logic [14:0] ccNext; // Next counter value
    logic done; // Completion pulse
    logic skip; // Next instruction skipped
    logic [5:0] cont; // Contingency indicators
    logic [3:0] code; // Address fault code, zero if none
    logic [2:0] chk; // Check faults, values 16/32/64
    logic cMode; // Contingency interrupt mode
    logic pMode; // Processor fault interrupt mode
    logic inhibit; // All interrupts held off
    logic fresh; // Inhibit set by the clear now finishing
    logic [3:0] status; // Sticky event bits
    logic [3:0] mask; // Interrupt enables
    logic [31:0] prdata; // Read data for the bus
  } itr_regs_t;

  itr_regs_t s_r; // Registered state
  itr_regs_t s_nxt; // Next state
  logic isTest; // Held word is a test
  logic isClear; // Held word is a clear
  logic [5:0] selCont; // Contingency flags selected
  logic codeSel; // A fault code is selected
  logic [2:0] selChk; // Check flags selected
  logic anyCont; // Some contingency flag selected
  logic anyPerr; // Some fault flag selected
  logic hit; // Test outcome
  logic issue; // Instruction accepted this cycle
  logic busWr; // Bus write completes this cycle
  logic busRdSetup; // Bus read setup phase
  logic codeMatch; // Selected code equals the stored one

  // Field decode of the held instruction
  itr_decode u_dec (
    .word(s_r.word),
    .cont(s_r.cont),
    .code(s_r.code),
    .chk(s_r.chk),
    .isTest(isTest),
    .isClear(isClear),
    .selCont(selCont),
    .codeSel(codeSel),
    .selChk(selChk),
    .anyCont(anyCont),
    .anyPerr(anyPerr),
    .hit(hit)
  );

  // Decoded register address is one of the three words
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == itr_pkg::ADDR_STATUS) || (a == itr_pkg::ADDR_MASK)
      || (a == itr_pkg::ADDR_FLAGS);
  endfunction

  // Handshakes and bus phases
  always_comb begin
    instrReady = (s_r.st == itr_pkg::ST_IDLE);
    issue = instrValid && instrReady
      && itr_pkg::itr_is_op(instrWord[itr_pkg::OP_HI:itr_pkg::OP_LO]);
    busWr = psel && penable && pwrite && mapped(paddr);
    busRdSetup = psel && !penable && !pwrite;
    codeMatch = codeSel
      && (s_r.word[4:1] == s_r.code);
  end

  // Next-state logic: clears first, then sets so events win
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.fresh = 1'b0;
    // Following instruction finished: lift the inhibit, but never on
    // the completion cycle of the clear that raised it
    if ((instrRetire || s_r.done) && !s_r.fresh) begin
      s_nxt.inhibit = 1'b0;
    end
    case (s_r.st)
      itr_pkg::ST_IDLE: begin
        // Accept a new test or clear
        if (issue) begin
          s_nxt.word = instrWord;
          s_nxt.ccBase = ccIn;
          if (instrWord[itr_pkg::IND_BIT]) begin
            s_nxt.st = itr_pkg::ST_IND;
          end else begin
            s_nxt.st = itr_pkg::ST_EXEC;
          end
        end
      end
      itr_pkg::ST_IND: begin
        // Fetched word replaces class and selection, may chain
        if (indAck) begin
          s_nxt.word[14:1] = indData[14:1];
          s_nxt.word[itr_pkg::IND_BIT] = indData[itr_pkg::IND_BIT];
          if (!indData[itr_pkg::IND_BIT]) begin
            s_nxt.st = itr_pkg::ST_EXEC;
          end
        end
      end
      itr_pkg::ST_EXEC: begin
        // Second cycle: commit outcome and counter
        s_nxt.st = itr_pkg::ST_IDLE;
        s_nxt.done = 1'b1;
        if (isTest) begin
          // Flags are only read here
          s_nxt.skip = !hit;
          s_nxt.ccNext = s_r.ccBase
            + (hit ? itr_pkg::CC_STEP : itr_pkg::CC_SKIP);
          s_nxt.status[itr_pkg::SB_TEST] = 1'b1;
        end else begin
          s_nxt.skip = 1'b0;
          s_nxt.ccNext = s_r.ccBase + itr_pkg::CC_STEP;
          s_nxt.status[itr_pkg::SB_CLEAR] = 1'b1;
          // Clearing clear flags is harmless, no error path
          s_nxt.cont = s_r.cont & ~selCont;
          s_nxt.chk = s_r.chk & ~selChk;
          if (codeMatch) begin
            s_nxt.code = 4'h0;
          end
          if (anyCont) begin
            s_nxt.cMode = 1'b0;
            s_nxt.inhibit = 1'b1;
          end
          if (anyPerr) begin
            s_nxt.pMode = 1'b0;
            s_nxt.inhibit = 1'b1;
          end
          // Own done pulse must not lift the new inhibit
          if (anyCont || anyPerr) begin
            s_nxt.fresh = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = itr_pkg::ST_IDLE;
      end
    endcase
    // Software writes: mask, or write-one-to-clear status
    if (busWr && (paddr == itr_pkg::ADDR_MASK)) begin
      s_nxt.mask = pwdata[3:0];
    end
    if (busWr && (paddr == itr_pkg::ADDR_STATUS)) begin
      s_nxt.status = s_nxt.status & ~pwdata[3:0];
    end
    // Hardware events set flags, winning over any clear
    s_nxt.cont = s_nxt.cont | contEvent;
    s_nxt.chk = s_nxt.chk | perrChkEvent;
    if (perrAddrEvent) begin
      s_nxt.code = perrAddrCode;
    end
    if (|contEvent) begin
      s_nxt.status[itr_pkg::SB_CONT] = 1'b1;
    end
    if (perrAddrEvent || (|perrChkEvent)) begin
      s_nxt.status[itr_pkg::SB_PERR] = 1'b1;
    end
    if (s_r.st == itr_pkg::ST_EXEC) begin
      s_nxt.status[itr_pkg::SB_TEST] = s_nxt.status[itr_pkg::SB_TEST]
        | isTest;
      s_nxt.status[itr_pkg::SB_CLEAR] = s_nxt.status[itr_pkg::SB_CLEAR]
        | isClear;
    end
    // Interrupt entry sets the matching mode
    if (contIntTaken) begin
      s_nxt.cMode = 1'b1;
    end
    if (perrIntTaken) begin
      s_nxt.pMode = 1'b1;
    end
    // Read data captured in the setup phase
    s_nxt.prdata = 32'h00000000;
    if (busRdSetup) begin
      case (paddr)
        itr_pkg::ADDR_STATUS: begin
          s_nxt.prdata[3:0] = s_r.status;
        end
        itr_pkg::ADDR_MASK: begin
          s_nxt.prdata[3:0] = s_r.mask;
        end
        itr_pkg::ADDR_FLAGS: begin
          s_nxt.prdata[itr_pkg::FL_CONT_LO +: 6] = s_r.cont;
          s_nxt.prdata[itr_pkg::FL_CODE_LO +: 4] = s_r.code;
          s_nxt.prdata[itr_pkg::FL_CHK_LO +: 3] = s_r.chk;
          s_nxt.prdata[itr_pkg::FL_CMODE] = s_r.cMode;
          s_nxt.prdata[itr_pkg::FL_PMODE] = s_r.pMode;
          s_nxt.prdata[itr_pkg::FL_INH] = s_r.inhibit;
        end
        default: begin
          s_nxt.prdata = 32'h00000000;
        end
      endcase
    end else if (psel && penable) begin
      // Hold read data through the access phase
      s_nxt.prdata = s_r.prdata;
    end
    // Synchronous reset
    if (!rst_n) begin
      s_nxt = '0;
      s_nxt.st = itr_pkg::ST_IDLE;
      s_nxt.mask = itr_pkg::MASK_RESET;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    s_r <= s_nxt;
  end

  // Outputs from state; pready tied high, pslverr from the bus inputs
  always_comb begin
    indReq = (s_r.st == itr_pkg::ST_IND);
    indAddr = s_r.word[14:1];
    execDone = s_r.done;
    skipNext = s_r.skip;
    ccNext = s_r.ccNext;
    contMode = s_r.cMode;
    perrMode = s_r.pMode;
    intrInhibit = s_r.inhibit;
    contPending = |s_r.cont;
    perrPending = (s_r.code != 4'h0) || (|s_r.chk);
    irq = |(s_r.status & s_r.mask);
    prdata = s_r.prdata;
    pready = 1'b1;
    pslverr = psel && penable && !mapped(paddr);
  end

  // Checks on the unit's own behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic quiet; // No indicator event this cycle
  assign quiet = !(|contEvent) && !perrAddrEvent && !(|perrChkEvent);

  // Direct instruction accepted
  sequence issueDirect;
    issue && !instrWord[itr_pkg::IND_BIT];
  endsequence
  // Indirect instruction accepted
  sequence issueIndirect;
    issue && instrWord[itr_pkg::IND_BIT];
  endsequence
  // Execution cycle of a test
  sequence execTest;
    (s_r.st == itr_pkg::ST_EXEC) && isTest;
  endsequence
  // Execution cycle of a clear
  sequence execClear;
    (s_r.st == itr_pkg::ST_EXEC) && isClear;
  endsequence

  a_two_cycle_exec: assert property (
    issueDirect |=> !execDone ##1 execDone)
    else $error("execution did not finish in two cycles");
  a_skip_count: assert property (
    execTest |=> execDone && (ccNext == $past(s_r.ccBase)
      + (skipNext ? 15'h0002 : 15'h0001)) && (skipNext == !$past(hit)))
    else $error("test counter advance wrong");
  a_test_readonly: assert property (
    execTest and quiet |=> (s_r.cont == $past(s_r.cont))
      && (s_r.chk == $past(s_r.chk)) && (s_r.code == $past(s_r.code)))
    else $error("test altered an indicator");
  a_unused_select: assert property (
    execTest and (s_r.word[10:7] != 4'h0
      && s_r.word[itr_pkg::CLS_HI:itr_pkg::CLS_LO] == itr_pkg::CLS_CONT
      && (s_r.word[6:1] & s_r.cont) == 6'h00) |=> skipNext)
    else $error("undefined select bit changed outcome");
  a_cont_cleared: assert property (
    execClear and quiet |=> ((s_r.cont & $past(selCont)) == 6'h00)
      && (ccNext == $past(s_r.ccBase) + 15'h0001))
    else $error("selected contingency flag survived clear");
  a_cont_mode: assert property (
    execClear and (anyCont && !contIntTaken)
      |=> !contMode && intrInhibit)
    else $error("contingency mode not ended by clear");
  a_perr_mode: assert property (
    execClear and (anyPerr && !perrIntTaken)
      |=> !perrMode && intrInhibit)
    else $error("fault mode not ended by clear");
  a_inhibit_hold: assert property (
    intrInhibit && !instrRetire && !execDone |=> intrInhibit)
    else $error("inhibit dropped before next instruction");
  a_inhibit_span: assert property (
    execClear and (anyCont || anyPerr) |=> intrInhibit ##1 intrInhibit)
    else $error("inhibit lifted by the clear itself");
  a_indirect_wait: assert property (
    issueIndirect |=> indReq && !execDone)
    else $error("indirect word not fetched first");
  a_code_test: assert property (
    execTest and (codeSel && s_r.word[4:1] == s_r.code) |=> !skipNext)
    else $error("matching fault code not reported set");
endmodule
`default_nettype wire

// [interrupt_indicator_test_reset_tb_top.sv]
// Self-checking bench for the indicator test and clear unit
`timescale 1ns/10ps
`default_nettype none
module interrupt_indicator_test_reset_tb_top;
  // Stimulus driven by the bench
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic instrValid = 1'b0;
  logic [25:1] instrWord = '0;
  logic [14:0] ccIn = '0;
  logic [25:1] indData = '0;
  logic indAck = 1'b0;
  logic [5:0] contEvent = '0;
  logic perrAddrEvent = 1'b0;
  logic [3:0] perrAddrCode = '0;
  logic [2:0] perrChkEvent = '0;
  logic [2:0] ctlPulse = '0; // Retire, fault taken, contingency taken
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  // Design outputs
  logic instrReady, indReq, execDone, skipNext, contMode, perrMode;
  logic intrInhibit, contPending, perrPending, irq, pready, pslverr;
  logic [14:1] indAddr;
  logic [14:0] ccNext;
  logic [31:0] prdata;
  // Counters, expectation queues and indicator model
  int mismatches = 0, check_count = 0, i;
  logic [15:0] execQ[$];
  logic [33:0] apbQ[$];
  logic [33:0] note;
  logic [5:0] mCont = '0;
  logic [3:0] mCode = '0;
  logic [2:0] mChk = '0;
  logic mCm = 1'b0, mPm = 1'b0, mInh = 1'b0;

  // Free-running core clock
  always #20 core_clk = ~core_clk;

  itr_unit dut (.core_clk(core_clk), .rst_n(rst_n), .instrValid(instrValid),
    .instrWord(instrWord), .ccIn(ccIn), .instrReady(instrReady),
    .indReq(indReq), .indAddr(indAddr), .indData(indData), .indAck(indAck),
    .execDone(execDone), .skipNext(skipNext), .ccNext(ccNext),
    .contEvent(contEvent), .perrAddrEvent(perrAddrEvent),
    .perrAddrCode(perrAddrCode), .perrChkEvent(perrChkEvent),
    .contIntTaken(ctlPulse[0]), .perrIntTaken(ctlPulse[1]),
    .instrRetire(ctlPulse[2]), .contMode(contMode), .perrMode(perrMode),
    .intrInhibit(intrInhibit), .contPending(contPending),
    .perrPending(perrPending), .irq(irq), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Generic word compare, counts every check
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Completion result: skip flag and next counter
  task automatic cmp_exec(input logic [15:0] exp);
    cmp_word({16'h0, skipNext, ccNext}, {16'h0, exp});
  endtask

  // Bus result: read data for reads, error flag always
  task automatic cmp_apb(input logic [33:0] exp);
    if (exp[33]) cmp_word(prdata, exp[31:0]);
    cmp_word({31'h0, pslverr}, {31'h0, exp[32]});
  endtask

  // A handshake wait that ran out counts as a mismatch
  task automatic waited(input int n);
    if (n >= 50) begin
      mismatches++;
      $display("CHECK FAILED at %0t: handshake wait timed out", $time);
    end
  endtask

  // Monitor: pops the oldest note whenever a result shows
  always @(negedge core_clk) begin
    if (rst_n === 1'b1 && execDone !== 1'b0) begin
      if (execQ.size() == 0) cmp_word({31'h0, execDone}, 32'h0);
      else cmp_exec(execQ.pop_front());
    end
    if (psel && penable && pready === 1'b1 && apbQ.size() > 0) begin
      note = apbQ.pop_front();
      cmp_apb(note);
    end
  end

  // Expected skip decision of a test
  function automatic logic model_hit(input logic [3:0] cls,
                                     input logic [9:0] sel);
    if (cls == itr_pkg::CLS_CONT) return |(sel[5:0] & mCont);
    if (cls == itr_pkg::CLS_PERR)
      return (sel[3:0] != 4'h0 && sel[3:0] == mCode) || |(sel[6:4] & mChk);
    return 1'b0;
  endfunction

  // Expected flags register image
  function automatic logic [31:0] flags_exp();
    return {13'h0, mInh, mPm, mCm, 1'b0, mChk, mCode, 2'b0, mCont};
  endfunction

  // One APB transfer, held until pready at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    int n;
    n = 0;
    apbQ.push_back({!wr, err, exp});
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(negedge core_clk); while (pready !== 1'b1 && ++n < 50);
    waited(n);
    @(posedge core_clk);
    psel <= 1'b0; penable <= 1'b0; pwdata <= ~d;
  endtask

  // Flags register and the level outputs against the model
  task automatic check_flags();
    apb(1'b0, itr_pkg::ADDR_FLAGS, 32'h0, flags_exp(), 1'b0);
    @(negedge core_clk);
    cmp_word({27'h0, intrInhibit, perrMode, contMode, perrPending, contPending},
      {27'h0, mInh, mPm, mCm, |{mCode, mChk}, |mCont});
  endtask

  // Indicator set pulses for one cycle
  task automatic events(input logic [5:0] c, input logic [3:0] code,
                        input logic [2:0] chk);
    @(posedge core_clk);
    contEvent <= c; perrAddrEvent <= (code != 4'h0);
    perrAddrCode <= code; perrChkEvent <= chk;
    @(posedge core_clk);
    contEvent <= '0; perrAddrEvent <= 1'b0; perrChkEvent <= '0;
    mCont |= c;
    if (code != 4'h0) mCode = code;
    mChk |= chk;
  endtask

  // Mode entry or retire pulse for one cycle
  task automatic ctl(input logic [2:0] v);
    @(posedge core_clk);
    ctlPulse <= v;
    @(posedge core_clk);
    ctlPulse <= '0;
    if (v[0]) mCm = 1'b1;
    if (v[1]) mPm = 1'b1;
    if (v[2]) mInh = 1'b0;
  endtask

  // Runs one test or clear, with hops levels of indirection
  task automatic run(input logic [5:0] op, input logic [3:0] cls,
                     input logic [9:0] sel, input int hops);
    logic [25:1] w;
    logic [14:0] cc;
    logic skip;
    int n;
    cc = 15'($urandom);
    skip = (op == itr_pkg::OP_TEST) && !model_hit(cls, sel);
    // Skip steps over the jump word that follows each test
    execQ.push_back({skip,
      cc + (skip ? itr_pkg::CC_SKIP : itr_pkg::CC_STEP)});
    mInh = 1'b0;
    if (op == itr_pkg::OP_CLEAR && cls == itr_pkg::CLS_CONT) begin
      mCont &= ~sel[5:0];
      if (sel[5:0] != 6'h0) {mCm, mInh} = 2'b01;
    end else if (op == itr_pkg::OP_CLEAR && cls == itr_pkg::CLS_PERR) begin
      if (sel[3:0] != 4'h0 && sel[3:0] == mCode) mCode = 4'h0;
      mChk &= ~sel[6:4];
      if (sel[6:0] != 7'h0) {mPm, mInh} = 2'b01;
    end
    if (hops == 0) w = {1'b0, 4'($urandom), op, cls, sel};
    else w = {1'b1, 4'($urandom), op, 14'($urandom)};
    @(posedge core_clk);
    instrValid <= 1'b1; instrWord <= w; ccIn <= cc;
    n = 0;
    do @(negedge core_clk); while (instrReady !== 1'b1 && ++n < 50);
    waited(n);
    @(posedge core_clk);
    instrValid <= 1'b0; instrWord <= ~w;
    for (int h = hops; h > 0; h--) begin
      n = 0;
      do @(negedge core_clk); while (indReq !== 1'b1 && ++n < 50);
      waited(n);
      cmp_word({18'h0, indAddr}, {18'h0, w[14:1]});
      repeat ($urandom_range(2)) @(posedge core_clk);
      if (h > 1) w = {1'b1, 10'($urandom), 14'($urandom)};
      else w = {1'b0, 10'($urandom), cls, sel};
      @(posedge core_clk);
      indAck <= 1'b1; indData <= w;
      @(posedge core_clk);
      indAck <= 1'b0; indData <= ~w;
    end
    n = 0;
    do @(negedge core_clk); while (execDone !== 1'b1 && ++n < 50);
    waited(n);
  endtask

  // Verdict and end of run
  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #(40 * 30000);
    mismatches++;
    give_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(236));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, itr_pkg::ADDR_STATUS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, itr_pkg::ADDR_MASK, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h0c, 32'h5, 32'h0, 1'b1);
    check_flags();
    // Each contingency flag alone; high select bits never hit
    for (i = 0; i < itr_pkg::CONT_W; i++) begin
      events(6'(1 << i), 4'h0, 3'h0);
      run(itr_pkg::OP_TEST, itr_pkg::CLS_CONT, 10'(1 << i), 0);
      run(itr_pkg::OP_TEST, itr_pkg::CLS_CONT, 10'h3c0, 0);
    end
    run(itr_pkg::OP_TEST, 4'h3, 10'h3ff, 0);
    run(itr_pkg::OP_TEST, itr_pkg::CLS_PERR, 10'h03f, 0);
    check_flags();
    // Fault codes and the three check indicators
    for (i = 1; i < 16; i += 7) begin
      events(6'h0, 4'(i), 3'h0);
      run(itr_pkg::OP_TEST, itr_pkg::CLS_PERR, 10'(i), 0);
      run(itr_pkg::OP_TEST, itr_pkg::CLS_PERR, 10'(i ^ 3), 0);
    end
    for (i = 0; i < itr_pkg::CHK_W; i++) begin
      events(6'h0, 4'h0, 3'(1 << i));
      run(itr_pkg::OP_TEST, itr_pkg::CLS_PERR, 10'(16 << i), 0);
    end
    check_flags();
    // Clears, modes and the one-instruction inhibit
    ctl(3'b011);
    check_flags();
    run(itr_pkg::OP_CLEAR, itr_pkg::CLS_CONT, 10'h001, 0);
    check_flags();
    ctl(3'b100);
    check_flags();
    run(itr_pkg::OP_CLEAR, itr_pkg::CLS_CONT, 10'h001, 0);
    run(itr_pkg::OP_TEST, itr_pkg::CLS_CONT, 10'h002, 0);
    check_flags();
    run(itr_pkg::OP_CLEAR, itr_pkg::CLS_PERR, 10'h040, 0);
    check_flags();
    // Indirect words, single and chained
    run(itr_pkg::OP_TEST, itr_pkg::CLS_CONT, 10'h020, 1);
    run(itr_pkg::OP_TEST, itr_pkg::CLS_PERR, 10'h020, 2);
    run(itr_pkg::OP_CLEAR, itr_pkg::CLS_CONT, 10'h03e, 1);
    check_flags();
    // Another opcode is never taken
    @(posedge core_clk);
    instrValid <= 1'b1; instrWord <= {1'b0, 4'h0, 6'h00, 4'h2, 10'h1};
    repeat (3) @(posedge core_clk);
    instrValid <= 1'b0;
    // Interrupt: status sticky, mask gating, write-one clear
    apb(1'b1, itr_pkg::ADDR_STATUS, 32'hf, 32'h0, 1'b0);
    apb(1'b1, itr_pkg::ADDR_MASK, 32'h1, 32'h0, 1'b0);
    @(negedge core_clk);
    cmp_word({31'h0, irq}, 32'h0);
    run(itr_pkg::OP_TEST, itr_pkg::CLS_CONT, 10'h001, 0);
    apb(1'b0, itr_pkg::ADDR_MASK, 32'h0, 32'h1, 1'b0);
    @(negedge core_clk);
    cmp_word({31'h0, irq}, 32'h1);
    apb(1'b1, itr_pkg::ADDR_STATUS, 32'h1, 32'h0, 1'b0);
    @(negedge core_clk);
    cmp_word({31'h0, irq}, 32'h0);
    // Random tests against the model
    for (i = 0; i < 16; i++) begin
      events(6'($urandom), 4'($urandom), 3'($urandom));
      run(itr_pkg::OP_TEST, $urandom_range(1) ? itr_pkg::CLS_CONT :
        itr_pkg::CLS_PERR, 10'($urandom), 0);
    end
    check_flags();
    give_verdict();
  end
endmodule
`default_nettype wire
